// [logic/acdm_ctrl.v]
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "acdm_map.vh"

// Summary of operation
// - with splitting off the block runs full rate whatever the rate select, and overrange follows only the primary sample.
// - with splitting on, overrange is set if either the primary or the auxiliary sample is overranged.
// - with splitting on, the one-to-two demultiplexer sends words at half or a quarter of the sample rate across both ports.
// - codes are offset binary and a zero difference gives a midscale code.
// - positive full scale gives all ones with overrange clear, set only above it; negative zero scale gives all zeros with overrange clear.
// - the reset passes a double latch and a latency pipeline, then feeds both the strobe generator and the reset output driver.
// - with splitting on, low rate select picks half rate and high rate select picks quarter rate.
// - in half rate each strobe rise shows the older sample on auxiliary and the newer on primary.
// - in quarter rate every other sample is dropped and the rest are demultiplexed at a quarter rate per port.
// - the reset input resets the internal demultiplexer and a matching reset output is driven.
module acdm_ctrl #(
   parameter PIPE_DEPTH = `ACDM_PIPE_DEPTH
) (
   input wire clk_sys,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   input wire sample_clk,
   input wire [8:0] sample_diff,
   input wire sync_reset_in,
   output wire [7:0] primary_port,
   output wire [7:0] auxiliary_port,
   output wire overrange,
   output wire sync_reset_out,
   output wire output_strobe,
   output wire word_valid,
   input wire word_ready
);
   // quantizer: two's complement difference to offset binary code plus overrange
   function [8:0] acdm_code;
      input [8:0] diff;
      begin
         if (!diff[8] && diff >= `ACDM_DIFF_MAX) begin
            acdm_code = {diff != `ACDM_DIFF_MAX, `ACDM_CODE_FULL};
         end else if (diff[8] && diff <= `ACDM_DIFF_MIN) begin
            acdm_code = {1'b0, `ACDM_CODE_ZERO};
         end else begin
            acdm_code = {1'b0, diff[7:0] ^ `ACDM_CODE_MID};
         end
      end
   endfunction

   // pairs the held older sample with the newer one; overrange covers both halves
   function [17:0] acdm_pair;
      input rst_mark;
      input [8:0] older;
      input [8:0] newer;
      begin
         acdm_pair = {rst_mark, older[8] | newer[8], older[7:0], newer[7:0]};
      end
   endfunction

   reg [1:0] ctrl_ff;
   reg drop_ff;
   reg [15:0] words_ff;
   reg sclk_s1_ff;
   reg sclk_s2_ff;
   reg sclk_d_ff;
   reg [8:0] diff_s1_ff;
   reg [8:0] diff_s2_ff;
   reg rin_s1_ff;
   reg rin_s2_ff;
   reg [1:0] latch_ff;
   reg [PIPE_DEPTH-1:0] pipe_ff;
   reg [1:0] cnt_ff;
   reg strobe_ff;
   reg sync_reset_out_ff;
   reg [8:0] hold_ff;
   reg [8:0] last_ff;
   reg emit_ff;
   reg [17:0] word_ff;
   reg [1:0] mode;
   reg [1:0] nxt_cnt;
   reg nxt_strobe;
   wire sclk_rise;
   wire sclk_fall;
   wire [8:0] conv;
   wire rst_end;
   wire buf_ready;
   wire [17:0] buf_data;
   wire apb_wr;
   wire apb_rd;
   wire hit;

   // mode decode from the split and rate bits
   always @* begin
      if (!ctrl_ff[`ACDM_CTRL_SPLIT_BIT]) begin
         mode = `ACDM_MODE_FULL;
      end else if (ctrl_ff[`ACDM_CTRL_RATE_BIT]) begin
         mode = `ACDM_MODE_QUARTER;
      end else begin
         mode = `ACDM_MODE_HALF;
      end
   end

   // sample clock, sample data and reset pin pass two flops before any use
   always @(posedge clk_sys) begin
      if (rst) begin
         sclk_s1_ff <= 1'b0;
         sclk_s2_ff <= 1'b0;
         sclk_d_ff <= 1'b0;
         diff_s1_ff <= 9'h000;
         diff_s2_ff <= 9'h000;
         rin_s1_ff <= 1'b0;
         rin_s2_ff <= 1'b0;
      end else begin
         sclk_s1_ff <= sample_clk;
         sclk_s2_ff <= sclk_s1_ff;
         sclk_d_ff <= sclk_s2_ff;
         diff_s1_ff <= sample_diff;
         diff_s2_ff <= diff_s1_ff;
         rin_s1_ff <= sync_reset_in;
         rin_s2_ff <= rin_s1_ff;
      end
   end

   assign sclk_rise = sclk_s2_ff & ~sclk_d_ff;
   assign sclk_fall = ~sclk_s2_ff & sclk_d_ff;
   assign conv = acdm_code(diff_s2_ff);

   // reset path: double latch then latency pipeline, both stepped by sample edges
   always @(posedge clk_sys) begin
      if (rst) begin
         latch_ff <= 2'h0;
         pipe_ff <= {PIPE_DEPTH{1'b0}};
      end else if (sclk_rise) begin
         latch_ff <= {latch_ff[0], rin_s2_ff};
         pipe_ff <= {pipe_ff[PIPE_DEPTH-2:0], latch_ff[1]};
      end
   end

   // last pipelined reset edge: the generator takes its known phase here
   assign rst_end = pipe_ff[PIPE_DEPTH-1] & ~pipe_ff[PIPE_DEPTH-2];

   // strobe generator: keeps toggling during reset so outside demuxes stay clocked
   always @* begin
      nxt_cnt = cnt_ff + 2'h1;
      nxt_strobe = strobe_ff;
      case (mode)
         `ACDM_MODE_FULL: begin
            nxt_strobe = 1'b1;
         end
         `ACDM_MODE_HALF: begin
            nxt_strobe = cnt_ff[0];
         end
         `ACDM_MODE_QUARTER: begin
            nxt_strobe = cnt_ff[1];
         end
         default: begin
            nxt_strobe = 1'b0;
         end
      endcase
      if (rst_end) begin
         nxt_cnt = 2'h0;
         nxt_strobe = 1'b0;
      end
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         cnt_ff <= 2'h0;
         strobe_ff <= 1'b0;
         sync_reset_out_ff <= 1'b0;
      end else if (sclk_rise) begin
         cnt_ff <= nxt_cnt;
         strobe_ff <= nxt_strobe;
         sync_reset_out_ff <= pipe_ff[PIPE_DEPTH-1];
      end else if (sclk_fall && mode == `ACDM_MODE_FULL) begin
         strobe_ff <= 1'b0; // full rate strobe follows the sample clock
      end
   end

   // demultiplexer: gathers samples into auxiliary/primary word pairs
   always @(posedge clk_sys) begin
      if (rst) begin
         hold_ff <= 9'h000;
         last_ff <= 9'h000;
         emit_ff <= 1'b0;
         word_ff <= 18'h00000;
      end else begin
         emit_ff <= 1'b0;
         if (sclk_rise) begin
            last_ff <= conv;
            if (rst_end) begin
               hold_ff <= 9'h000; // pair restarts in the reset phase
            end else begin
               case (mode)
                  `ACDM_MODE_FULL: begin
                     // auxiliary repeats the previous sample; overrange from primary only
                     word_ff <= {sync_reset_out_ff, conv[8], last_ff[7:0], conv[7:0]};
                     emit_ff <= 1'b1;
                  end
                  `ACDM_MODE_HALF: begin
                     if (!cnt_ff[0]) begin
                        hold_ff <= conv;
                     end else begin
                        word_ff <= acdm_pair(sync_reset_out_ff, hold_ff, conv);
                        emit_ff <= 1'b1;
                     end
                  end
                  `ACDM_MODE_QUARTER: begin
                     // samples at counts 1 and 3 are discarded
                     if (cnt_ff == 2'h0) begin
                        hold_ff <= conv;
                     end else if (cnt_ff == 2'h2) begin
                        word_ff <= acdm_pair(sync_reset_out_ff, hold_ff, conv);
                        emit_ff <= 1'b1;
                     end
                  end
                  default: begin
                     hold_ff <= hold_ff;
                  end
               endcase
            end
         end
      end
   end

   // buffer absorbs receiver stalls; a word offered while full sets the sticky drop flag
   acdm_buf #(
      .W(18)
   ) u_buf (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_valid(emit_ff),
      .in_data(word_ff),
      .in_ready(buf_ready),
      .out_valid(word_valid),
      .out_data(buf_data),
      .out_ready(word_ready)
   );

   assign primary_port = buf_data[7:0];
   assign auxiliary_port = buf_data[15:8];
   assign overrange = buf_data[16];
   assign sync_reset_out = sync_reset_out_ff;
   assign output_strobe = strobe_ff;

   // apb slave: zero wait states, error on unmapped addresses
   assign pready = 1'b1;
   assign apb_wr = psel & penable & pwrite;
   assign apb_rd = psel & penable & ~pwrite;
   assign hit = (paddr == `ACDM_REG_CTRL) | (paddr == `ACDM_REG_STATUS) | (paddr == `ACDM_REG_WORDS);

   // control writes; software should change modes only before a sync reset
   always @(posedge clk_sys) begin
      if (rst) begin
         ctrl_ff <= `ACDM_CTRL_RESET;
      end else if (apb_wr && paddr == `ACDM_REG_CTRL) begin
         ctrl_ff <= pwdata[1:0];
      end
   end

   // drop flag: a new drop in the clearing cycle wins over the clear
   always @(posedge clk_sys) begin
      if (rst) begin
         drop_ff <= 1'b0;
         words_ff <= 16'h0000;
      end else begin
         if (emit_ff && !buf_ready) begin
            drop_ff <= 1'b1;
         end else if (apb_wr && paddr == `ACDM_REG_STATUS && pwdata[`ACDM_STAT_DROP_BIT]) begin
            drop_ff <= 1'b0;
         end
         if (emit_ff && buf_ready) begin
            words_ff <= words_ff + 16'h0001;
         end
      end
   end

   // read data driven combinationally in the access phase, error flag alongside
   always @* begin
      prdata = 32'h00000000;
      pslverr = psel & penable & ~hit;
      if (apb_rd) begin
         case (paddr)
            `ACDM_REG_CTRL: begin
               prdata = {30'h00000000, ctrl_ff};
            end
            `ACDM_REG_STATUS: begin
               prdata = {26'h0000000, cnt_ff, mode, sync_reset_out_ff, drop_ff};
            end
            `ACDM_REG_WORDS: begin
               prdata = {16'h0000, words_ff};
            end
            default: begin
               prdata = 32'h00000000;
            end
         endcase
      end
   end
endmodule // acdm_ctrl

// [logic/acdm_map.vh]
`ifndef ACDM_MAP_VH
`define ACDM_MAP_VH

// apb register byte offsets
`define ACDM_REG_CTRL 8'h00
`define ACDM_REG_STATUS 8'h04
`define ACDM_REG_WORDS 8'h08

// control register fields
`define ACDM_CTRL_SPLIT_BIT 0
`define ACDM_CTRL_RATE_BIT 1
`define ACDM_CTRL_RESET 2'h0

// status register fields
`define ACDM_STAT_DROP_BIT 0
`define ACDM_STAT_SYNC_RESET_OUT_BIT 1
`define ACDM_STAT_MODE_LSB 2
`define ACDM_STAT_PHASE_LSB 4

// output modes
`define ACDM_MODE_FULL 2'h0
`define ACDM_MODE_HALF 2'h1
`define ACDM_MODE_QUARTER 2'h2

// offset binary codes and quantizer limits
`define ACDM_CODE_MID 8'h80
`define ACDM_CODE_FULL 8'hff
`define ACDM_CODE_ZERO 8'h00
`define ACDM_DIFF_MAX 9'h07f
`define ACDM_DIFF_MIN 9'h180

// sample clocks of reset pipeline latency
`define ACDM_PIPE_DEPTH 6

`endif

// [logic/acdm_buf.v]
`timescale 1ns/1ps

// two-entry buffer: head register feeds the outputs, spare catches one word during a stall
module acdm_buf #(
   parameter W = 18
) (
   input wire clk_sys,
   input wire rst,
   input wire in_valid,
   input wire [W-1:0] in_data,
   output wire in_ready,
   output wire out_valid,
   output wire [W-1:0] out_data,
   input wire out_ready
);
   reg [W-1:0] head_ff;
   reg [W-1:0] spare_ff;
   reg head_vld_ff;
   reg spare_vld_ff;
   wire push;
   wire advance;

   // ready depends only on the spare slot, so it never loops back through out_ready
   assign in_ready = ~spare_vld_ff;
   assign out_valid = head_vld_ff;
   assign out_data = head_ff;
   assign push = in_valid & ~spare_vld_ff;
   assign advance = out_ready | ~head_vld_ff;

   // head refills from spare first so word order is kept
   always @(posedge clk_sys) begin
      if (rst) begin
         head_ff <= {W{1'b0}};
         spare_ff <= {W{1'b0}};
         head_vld_ff <= 1'b0;
         spare_vld_ff <= 1'b0;
      end else if (advance) begin
         if (spare_vld_ff) begin
            head_ff <= spare_ff;
            head_vld_ff <= 1'b1;
            spare_vld_ff <= 1'b0;
         end else if (push) begin
            head_ff <= in_data;
            head_vld_ff <= 1'b1;
         end else begin
            head_vld_ff <= 1'b0;
         end
      end else if (push) begin
         spare_ff <= in_data;
         spare_vld_ff <= 1'b1;
      end
   end
endmodule // acdm_buf

// [tb/acdm_cap.sv]
`timescale 1ns/1ps

// capture side: ready is registered, so a stall request takes one edge to bite
module acdm_cap (
   input wire clk_sys,
   input wire rst,
   input wire stall,
   input wire word_valid,
   input wire [7:0] primary_port,
   input wire [7:0] auxiliary_port,
   input wire overrange,
   output logic word_ready
);
   logic [16:0] q[$];

   // keep every taken word as {overrange, older, newer}
   always @(posedge clk_sys) begin
      if (word_valid && word_ready && !rst) begin
         q.push_back({overrange, auxiliary_port, primary_port});
      end
      word_ready <= !stall && !rst;
   end
endmodule // acdm_cap

// [tb/acdm_ctrl_chk.sv]
`timescale 1ns/1ps

module acdm_ctrl_chk (
   input wire clk_sys,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [7:0] primary_port,
   input wire [7:0] auxiliary_port,
   input wire overrange,
   input wire sync_reset_out,
   input wire output_strobe,
   input wire word_valid,
   input wire word_ready
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // access phase and decode of the three mapped words
   wire acc = psel && penable;
   wire map = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;

   // a refused word must not move while the receiver stalls
   sequence s_stall;
      word_valid && !word_ready;
   endsequence
   sequence s_held;
      word_valid && $stable(primary_port) && $stable(auxiliary_port) && $stable(overrange);
   endsequence

   a_ready_always: assert property (pready) else $error("pready low");
   a_bad_addr_err: assert property (acc && !map |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
   a_good_addr_ok: assert property (acc && map |-> !pslverr) else $error("mapped refused");
   a_idle_bus_zero: assert property (!acc |-> prdata == 32'h0) else $error("read data outside access");
   a_stall_word_held: assert property (s_stall |=> s_held) else $error("stalled word changed");
   a_ovr_code_full: assert property (
      word_valid && overrange |-> primary_port == 8'hff || auxiliary_port == 8'hff) else $error("overrange without full code");
   a_strobe_in_reset: assert property (
      $rose(sync_reset_out) |-> ##[1:40] $changed(output_strobe)) else $error("strobe stopped in reset");
   a_mode_field_legal: assert property (
      acc && !pwrite && paddr == 8'h04 |-> prdata[3:2] != 2'h3 && prdata[1] == sync_reset_out)
      else $error("bad status read");
endmodule // acdm_ctrl_chk

bind acdm_ctrl acdm_ctrl_chk u_chk (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .primary_port(primary_port),
   .auxiliary_port(auxiliary_port), .overrange(overrange), .sync_reset_out(sync_reset_out),
   .output_strobe(output_strobe), .word_valid(word_valid), .word_ready(word_ready));

// [tb/tb_adc_output_demux_mode_control.sv]
`timescale 1ns/1ps

module tb_adc_output_demux_mode_control;
   logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd;
   logic sample_clk = 1'b0, sclk_q = 1'b0, sync_reset_in = 1'b0, stall = 1'b0, err;
   logic [8:0] sample_diff = 9'h000, fix = 9'h000;
   logic [5:0] ramp = 6'h00;
   wire [31:0] prdata;
   wire [7:0] primary_port, auxiliary_port;
   wire pready, pslverr, overrange, sync_reset_out, output_strobe, word_valid, word_ready;
   int error_cnt = 0, check_count = 0, pat = 0;

   always #12.5 clk_sys = ~clk_sys;
   // sample clock free runs with a phase unrelated to clk_sys
   initial begin
      #7;
      forever #100 sample_clk = ~sample_clk;
   end
   // new difference after each sample fall: 0 ramp, 1 alternating overrange, 2 fixed
   always @(posedge clk_sys) begin
      sclk_q <= sample_clk;
      if (sclk_q && !sample_clk) begin
         ramp <= ramp + 6'h01;
         sample_diff <= pat == 0 ? {3'h0, ramp} : pat == 1 ? (ramp[0] ? 9'h0c8 : 9'h000) : fix;
      end
   end

   acdm_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_clk(sample_clk), .sample_diff(sample_diff), .sync_reset_in(sync_reset_in),
      .primary_port(primary_port), .auxiliary_port(auxiliary_port), .overrange(overrange),
      .sync_reset_out(sync_reset_out), .output_strobe(output_strobe), .word_valid(word_valid),
      .word_ready(word_ready));
   acdm_cap u_cap (.clk_sys(clk_sys), .rst(rst), .stall(stall), .word_valid(word_valid),
      .primary_port(primary_port), .auxiliary_port(auxiliary_port), .overrange(overrange),
      .word_ready(word_ready));

   task cmp(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one apb transfer; read data and error taken at the edge that ends it
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk_sys);
      end
      cmp("pready", pready, 1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task t_regs;
      apb(0, 8'h00, 0);
      cmp("ctrl reset", rd, 32'h0);
      apb(0, 8'h04, 0);
      cmp("status reset", rd & 32'hf, 32'h0);
      apb(1, 8'h00, 32'hffffffff);
      apb(1, 8'h0c, 32'h0);
      cmp("unmapped err", {31'h0, err}, 32'h1);
      apb(0, 8'h00, 0);
      cmp("ctrl rw", rd, 32'h3);
      apb(0, 8'h0c, 0);
      cmp("unmapped read", rd, 32'h0);
      apb(0, 8'h08, 0);
      cmp("words upper", rd & 32'hffff0000, 32'h0);
   endtask

   // a reset pulse of four samples; width of the echo tracks the input
   task sync_pulse;
      int n, t;
      n = 0;
      t = 0;
      sync_reset_in <= 1'b1;
      repeat (32) @(posedge clk_sys);
      sync_reset_in <= 1'b0;
      while (sync_reset_out !== 1'b1 && n < 150) begin
         n++;
         @(posedge clk_sys);
      end
      cmp("reset out delay", n >= 24 && n <= 88, 1);
      while (sync_reset_out === 1'b1 && t < 100) begin
         t++;
         @(posedge clk_sys);
      end
      cmp("reset out width", t >= 16 && t <= 48, 1);
      repeat (16) @(posedge clk_sys);
   endtask

   // mode only changes ahead of a demux reset
   task set_mode(input logic [1:0] m, input logic [1:0] md);
      apb(1, 8'h00, {30'h0, m});
      sync_pulse();
      apb(0, 8'h04, 0);
      cmp("mode", {30'h0, rd[3:2]}, {30'h0, md});
      u_cap.q.delete();
   endtask

   // ramp input: code steps inside and between words, word count per 64 samples
   task t_stream(input int dpa, input int dst, input int exp);
      int bad, rises;
      logic [7:0] p, a, pp;
      logic sq;
      bad = 0;
      rises = 0;
      sq = output_strobe;
      // strobe rises counted over the same span as the captured words
      for (int k = 0; k < 512; k++) begin
         @(posedge clk_sys);
         if (output_strobe && !sq) rises++;
         sq = output_strobe;
      end
      cmp("strobe rate", rises >= exp - 2 && rises <= exp + 1, 1);
      for (int i = 1; i < u_cap.q.size(); i++) begin
         p = u_cap.q[i][7:0];
         a = u_cap.q[i][15:8];
         pp = u_cap.q[i-1][7:0];
         if (((p - a) & 8'h3f) != dpa || ((a - pp) & 8'h3f) != dst) bad++;
      end
      cmp("word order", bad, 0);
      cmp("word rate", u_cap.q.size() >= exp - 2 && u_cap.q.size() <= exp + 1, 1);
   endtask

   // alternating overrange and midscale samples
   task t_ovr(input logic sp);
      int bad, seen;
      logic [7:0] p;
      bad = 0;
      seen = 0;
      pat <= 1;
      repeat (32) @(posedge clk_sys);
      u_cap.q.delete();
      repeat (256) @(posedge clk_sys);
      foreach (u_cap.q[i]) begin
         p = u_cap.q[i][7:0];
         if (p == 8'h80 || p == 8'hff) begin
            seen++;
            if (u_cap.q[i][16] !== (p == 8'hff || sp)) bad++;
         end
      end
      cmp("overrange", bad, 0);
      cmp("overrange seen", seen > 0, 1);
      pat <= 0;
   endtask

   // fixed differences at the ends and middle of the code range, {overrange, code}
   task t_codes;
      logic [8:0] dv[6] = '{9'h000, 9'h07f, 9'h080, 9'h180, 9'h181, 9'h1ff};
      logic [8:0] ev[6] = '{9'h080, 9'h0ff, 9'h1ff, 9'h000, 9'h001, 9'h07f};
      pat <= 2;
      for (int i = 0; i < 6; i++) begin
         fix <= dv[i];
         repeat (48) @(posedge clk_sys);
         cmp("code", {u_cap.q[$][16], u_cap.q[$][7:0]}, ev[i]);
      end
      pat <= 0;
   endtask

   // stall until the buffer drops words, then drain and clear the sticky flag
   task t_buf;
      int n;
      n = 0;
      stall <= 1'b1;
      repeat (100) @(posedge clk_sys);
      cmp("stalled valid", word_valid, 1);
      apb(0, 8'h04, 0);
      cmp("drop set", rd[0], 1);
      stall <= 1'b0;
      repeat (20) @(posedge clk_sys);
      apb(1, 8'h04, 32'h1);
      apb(0, 8'h04, 0);
      cmp("drop clear", rd[0], 0);
      while (word_valid !== 1'b0 && n < 20) begin
         n++;
         @(posedge clk_sys);
      end
      cmp("drained", word_valid, 0);
   endtask

   task end_of_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // main sequence: rate select alone keeps full rate
   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      set_mode(2'h2, 2'h0);
      t_stream(1, 0, 64);
      set_mode(2'h1, 2'h1);
      t_stream(1, 1, 32);
      t_ovr(1);
      set_mode(2'h3, 2'h2);
      t_stream(2, 2, 16);
      set_mode(2'h0, 2'h0);
      t_ovr(0);
      t_codes();
      t_buf();
      end_of_test();
   end
   // watchdog: about five times the expected run
   initial begin
      #400000;
      error_cnt++;
      end_of_test();
   end
endmodule // tb_adc_output_demux_mode_control
